// *** rtl/fppio_regs.svh ***
// register map, reset values and pin constants of the four-port parallel io block
// Functional notes
// - 32 pins, four 8-bit ports, per-pin direction
// - data latches at indices 0-3 survive reset
// - direction A-D at indices 4-7, reset zero
// - port A latch bit per pin, direction-steered
// - converter-selected port A pin given to converter
// - unselected port A pins stay digital io
// - peripheral enables claim their port pins
// - open-drain pins only pull low
// - per-pin LED drive select on port A
// - direction one drives, zero leaves input
// - read gives latch if output, else pin
// - latch always writable, reaches pin when output
`ifndef FPPIO_REGS_SVH
`define FPPIO_REGS_SVH

`define FPPIO_IDX_LATCH_A   4'h0
`define FPPIO_IDX_LATCH_B   4'h1
`define FPPIO_IDX_LATCH_C   4'h2
`define FPPIO_IDX_LATCH_D   4'h3
`define FPPIO_IDX_DIR_A     4'h4
`define FPPIO_IDX_DIR_B     4'h5
`define FPPIO_IDX_DIR_C     4'h6
`define FPPIO_IDX_DIR_D     4'h7
`define FPPIO_IDX_LED       4'h8
`define FPPIO_IDX_LAST      4'h8

`define FPPIO_DIR_RESET     8'h00
`define FPPIO_LED_RESET     8'h00
`define FPPIO_OD_MASK       32'h00c0_0f00
`define FPPIO_ADC_PINS      5'h08

`endif

// *** rtl/fppio_pkg.sv ***
// types of the four-port parallel io block
package fppio_pkg;

  typedef logic [3:0][7:0] fppio_port_t;

  typedef struct packed {
    fppio_port_t latch;
    fppio_port_t dir;
    logic [7:0]  led;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
    logic [7:0]  led_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fppio_state_t;

endpackage : fppio_pkg

// *** rtl/fppio_sync.sv ***
// two-flop synchroniser for the pin levels
module fppio_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : fppio_sync

// *** rtl/fppio_top.sv ***
// four-port parallel io block with apb register access
`include "fppio_regs.svh"

module fppio_top
  import fppio_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins, bit 8*port+n
  input  wire logic [31:0]       pad_in,
  output logic      [31:0]       pad_out,
  output logic      [31:0]       pad_oe,
  output logic      [7:0]        led_drive_en,
  output logic      [31:0]       pin_level,
  // peripheral enables
  input  wire logic [4:0]        converter_channel_select,
  input  wire logic              iic_module_enable,
  input  wire logic              serial_module_enable,
  input  wire logic              spi_module_enable,
  input  wire logic              ir_serial_module_enable,
  input  wire logic [3:0][1:0]   timer_edge_level_select,
  input  wire logic [7:0]        keyboard_pin_enable,
  // peripheral drive of claimed pins
  input  wire logic [31:0]       periph_out,
  input  wire logic [31:0]       periph_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  fppio_state_t     s_q;
  fppio_state_t     s_d;
  logic [31:0]      pin_sync;
  logic [3:0]       reg_idx;
  logic             addr_ok;
  logic             setup_ph;
  logic             access_ph;
  logic [31:0]      claim;
  logic [31:0]      analog;
  logic [31:0]      drive_val;
  logic [31:0]      drive_en;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  fppio_sync #(
    .WIDTH    (32)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // pins owned by on-chip peripherals
  function automatic logic [31:0] claim_mask(
    input logic            iic_en,
    input logic            sci_en,
    input logic            spi_en,
    input logic            irsci_en,
    input logic [3:0][1:0] tim_els,
    input logic [7:0]      kbd_en
  );
    logic [31:0] m;
    m = '0;
    m[9:8]   = {2{iic_en}};
    m[11:10] = {2{sci_en}};
    for (int i = 0; i < 4; i++) begin
      m[12+i] = |tim_els[i];
    end
    m[21:18] = {4{spi_en}};
    m[23:22] = {2{irsci_en}};
    m[31:24] = kbd_en;
    return m;
  endfunction : claim_mask

  // port A pin handed to the converter
  function automatic logic [31:0] analog_mask(
    input logic [4:0] chan
  );
    logic [31:0] m;
    m = '0;
    if (chan < `FPPIO_ADC_PINS) begin
      m[chan[2:0]] = 1'b1;
    end
    return m;                              // other pins stay digital
  endfunction : analog_mask

  // data read: latch for outputs, pin for inputs
  function automatic logic [7:0] port_read(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pin
  );
    return (latch & dir) | (pin & ~dir);
  endfunction : port_read

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable && s_q.pready;
  assign reg_idx   = paddr[5:2];
  assign addr_ok   = (paddr[1:0] == 2'h0)
                  && (paddr[ADDR_W-1:6] == '0)
                  && (reg_idx <= `FPPIO_IDX_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership and drive

  assign claim = claim_mask(iic_module_enable,
                            serial_module_enable,
                            spi_module_enable,
                            ir_serial_module_enable,
                            timer_edge_level_select,
                            keyboard_pin_enable);

  assign analog = analog_mask(converter_channel_select);

  always_comb begin
    for (int b = 0; b < 32; b++) begin
      if (analog[b]) begin
        drive_val[b] = 1'b0;
        drive_en[b]  = 1'b0;
      end else if (claim[b]) begin
        drive_val[b] = periph_out[b];
        drive_en[b]  = periph_oe[b];
      end else begin
        drive_val[b] = s_q.latch[b/8][b%8];
        drive_en[b]  = s_q.dir[b/8][b%8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // pins: open-drain bits only pull low
    s_d.pad_out = drive_val & ~`FPPIO_OD_MASK;
    s_d.pad_oe  = (drive_en & ~`FPPIO_OD_MASK)
                | (drive_en & ~drive_val & `FPPIO_OD_MASK);

    // led drive only on port A outputs
    s_d.led_en = s_q.led & s_q.dir[0] & ~analog[7:0];

    // answer phase, registered in the setup cycle
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup_ph) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !addr_ok;
      s_d.prdata  = '0;
      if (addr_ok && !pwrite) begin
        unique case (reg_idx)
          `FPPIO_IDX_LATCH_A,
          `FPPIO_IDX_LATCH_B,
          `FPPIO_IDX_LATCH_C,
          `FPPIO_IDX_LATCH_D: begin
            s_d.prdata[7:0] = port_read(s_q.latch[reg_idx[1:0]],
                                        s_q.dir[reg_idx[1:0]],
                                        pin_sync[reg_idx[1:0]*8 +: 8]);
          end
          `FPPIO_IDX_DIR_A,
          `FPPIO_IDX_DIR_B,
          `FPPIO_IDX_DIR_C,
          `FPPIO_IDX_DIR_D: begin
            s_d.prdata[7:0] = s_q.dir[reg_idx[1:0]];
          end
          default: begin
            s_d.prdata[7:0] = s_q.led;
          end
        endcase
      end
    end

    // writes take effect at the access edge
    if (access_ph && pwrite && addr_ok) begin
      unique case (reg_idx)
        `FPPIO_IDX_LATCH_A,
        `FPPIO_IDX_LATCH_B,
        `FPPIO_IDX_LATCH_C,
        `FPPIO_IDX_LATCH_D: begin
          s_d.latch[reg_idx[1:0]] = pwdata[7:0];
        end
        `FPPIO_IDX_DIR_A,
        `FPPIO_IDX_DIR_B,
        `FPPIO_IDX_DIR_C,
        `FPPIO_IDX_DIR_D: begin
          s_d.dir[reg_idx[1:0]] = pwdata[7:0];
        end
        default: begin
          s_d.led = pwdata[7:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; data latches have no reset

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // latch left out: kept through reset
      s_q.dir     <= {4{`FPPIO_DIR_RESET}};
      s_q.led     <= `FPPIO_LED_RESET;
      s_q.pad_out <= '0;
      s_q.pad_oe  <= '0;
      s_q.led_en  <= '0;
      s_q.prdata  <= '0;
      s_q.pready  <= 1'b0;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q.latch   <= s_d.latch;
      s_q.dir     <= s_d.dir;
      s_q.led     <= s_d.led;
      s_q.pad_out <= s_d.pad_out;
      s_q.pad_oe  <= s_d.pad_oe;
      s_q.led_en  <= s_d.led_en;
      s_q.prdata  <= s_d.prdata;
      s_q.pready  <= s_d.pready;
      s_q.pslverr <= s_d.pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign pad_out      = s_q.pad_out;
  assign pad_oe       = s_q.pad_oe;
  assign led_drive_en = s_q.led_en;
  assign pin_level    = pin_sync;

endmodule : fppio_top

// *** test/fppio_pins.sv ***
// pin-side model of the parallel io block
`include "fppio_regs.svh"
module fppio_pins (
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] ext_lvl,
  output logic     [31:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven pins follow the block, open-drain pins pulled up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (ext_lvl | `FPPIO_OD_MASK));
endmodule : fppio_pins

// *** test/fppio_monitor.sv ***
// port checker for the parallel io block
`include "fppio_regs.svh"
module fppio_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       pad_in,
  input wire logic [31:0]       pad_out,
  input wire logic [31:0]       pad_oe,
  input wire logic [7:0]        led_drive_en,
  input wire logic [31:0]       pin_level,
  input wire logic [4:0]        converter_channel_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] age_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence setup_s;
    psel && !penable;
  endsequence
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("pready late");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready long");
  bad_addr_a: assert property (setup_s ##0 paddr >= 'h40 |=> pslverr && prdata == 32'h0)
    else $error("bad address taken");
  high_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("rdata high bits");
  conv_oe_a: assert property (converter_channel_select < 5'h08 |=>
    !pad_oe[$past(converter_channel_select[2:0])])
    else $error("analog pin driven");
  od_low_a: assert property ((pad_out & `FPPIO_OD_MASK) == 32'h0)
    else $error("open drain high");
  led_oe_a: assert property ((led_drive_en & ~pad_oe[7:0]) == 8'h0)
    else $error("led on input");
  sync_lag_a: assert property (age_q == 2'h3 |-> pin_level == $past(pad_in, 2))
    else $error("sync lag");
endmodule : fppio_monitor
bind fppio_top fppio_monitor #(.ADDR_W(ADDR_W)) mon_u (.core_clk(core_clk), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .led_drive_en(led_drive_en), .pin_level(pin_level),
  .converter_channel_select(converter_channel_select));

// *** test/testbench.sv ***
// self-checking bench of the parallel io block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, re, iic, sci, spi, irs;
  logic [4:0]  ch;
  logic [7:0]  led, kbd, tels;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe, lvl, p_out, p_oe, ext, rv;
  int          err_count, total_checks, cyc;
  fppio_top dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .led_drive_en(led), .pin_level(lvl), .converter_channel_select(ch),
    .iic_module_enable(iic), .serial_module_enable(sci), .spi_module_enable(spi),
    .ir_serial_module_enable(irs), .timer_edge_level_select(tels),
    .keyboard_pin_enable(kbd), .periph_out(p_out), .periph_oe(p_oe));
  fppio_pins pins_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
  endtask : apb
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 4; i < 7; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("dir", 32'h0, rv);
      chk("err ok", 32'h0, {31'h0, re});
    end
    idle(1);
    chk("oe", 32'h0, pad_oe);
    chk("level", 32'h3ce9_af3c, lvl);
    $display("reset done");
  endtask : t_reset
  task automatic t_pins;
    apb(1'b1, 12'h000, 32'h5a);
    idle(3);
    apb(1'b0, 12'h000, 32'h0);
    chk("pin rd", {24'h0, ext[7:0]}, rv);
    for (int i = 1; i < 8; i++) apb(1'b1, 12'(4 * i), (i < 4) ? 32'h0 : 32'hff);
    idle(2);
    chk("out", 32'h5a, {24'h0, pad_out[7:0]});
    chk("oe all", 32'hffff_ffff, pad_oe);
    apb(1'b0, 12'h000, 32'h0);
    chk("latch rd", 32'h5a, rv);
    apb(1'b1, 12'h004, 32'hf5);
    idle(2);
    chk("od oe", 32'hfa, {24'h0, pad_oe[15:8]});
    chk("od out", 32'hf0, {24'h0, pad_out[15:8]});
    $display("pins done");
  endtask : t_pins
  task automatic t_keep;
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(1);
    apb(1'b0, 12'h010, 32'h0);
    chk("dir rst", 32'h0, rv);
    apb(1'b1, 12'h010, 32'hff);
    apb(1'b1, 12'h014, 32'hff);
    apb(1'b0, 12'h000, 32'h0);
    chk("keep a", 32'h5a, rv);
    apb(1'b0, 12'h004, 32'h0);
    chk("keep b", 32'hf5, rv);
    apb(1'b1, 12'h020, 32'hff);
    for (int i = 0; i < 9; i++) begin
      ch <= 5'(i);
      idle(2);
      chk("conv oe", 32'hff & ~(32'h1 << i), {24'h0, pad_oe[7:0]});
      chk("led", 32'hff & ~(32'h1 << i), {24'h0, led});
    end
    $display("keep done");
  endtask : t_keep
  task automatic t_claim;
    logic [31:0] m [6];
    m = '{32'h300, 32'hc00, 32'hf000, 32'h3c_0000, 32'hc0_0000, 32'hff00_0000};
    for (int i = 4; i < 8; i++) apb(1'b1, 12'(4 * i), 32'h0);
    p_oe <= 32'hffff_ffff;
    for (int k = 0; k < 6; k++) begin
      iic <= (k == 0);
      sci <= (k == 1);
      tels <= (k == 2) ? 8'he7 : 8'h00;
      spi <= (k == 3);
      irs <= (k == 4);
      kbd <= (k == 5) ? 8'hff : 8'h00;
      idle(2);
      chk("claim", m[k], pad_oe);
    end
    p_out <= 32'h5a00_0000;
    idle(2);
    chk("claim out", 32'h5a, {24'h0, pad_out[31:24]});
    apb(1'b0, 12'h024, 32'h0);
    chk("err rd", 32'h1, {31'h0, re});
    chk("rd zero", 32'h0, rv);
    apb(1'b1, 12'h041, 32'hff);
    chk("err wr", 32'h1, {31'h0, re});
    idle(1);
    $display("claim done");
  endtask : t_claim
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    {reset, psel, penable, pwrite, iic, sci, spi, irs} = 8'h80;
    paddr = 12'h0;
    pwdata = 32'h0;
    ch = 5'h08;
    tels = 8'h00;
    kbd = 8'h00;
    p_out = 32'h0;
    p_oe = 32'h0;
    ext = 32'h3c69_a53c;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_pins;
    t_keep;
    t_claim;
    summarize;
  end
endmodule : testbench
